//--- logic/sdc_core.sv
// Digital core of the frequency synthesizer: serial load, dividers, detector, lock detect, monitor.
//
// What this block does
// - Shift one data bit into 24-bit register per serial clock rise, MSB first.
// - Load strobe rising edge copies the shift word into exactly one latch.
// - Two low bits pick latch: 00 reference, 01 feedback, 10 function, 11 init.
// - Prescaler ratio pairs 8/9, 16/17, 32/33, 64/65 from the function latch field.
// - Feedback divides by swallow plus modulus times main count, by pulse swallowing.
// - Main counter is 13-bit binary, values 3 through 8191.
// - Swallow counter is 6-bit binary, values 0 through 63.
// - Reference divider is 14-bit, ratios 1 through 16383, feeding the detector.
// - Combined feedback divider is 19 bits: 6-bit swallow plus 13-bit main.
// - Detector compares both dividers; two reference-latch bits set antibacklash width.
// - Monitor pin driven from source picked by 3-bit function-latch field.
// - Precision clear: lock after three consecutive detector cycles under 15 ns error.
// - Precision set: lock after five consecutive detector cycles under 15 ns error.
// - Lock stays high until a detector cycle shows over 25 ns error, or until power-down clears it.
// - Reference latch: divide 15..2, width 17..16, tests, precision, sync, delay, ignored top.
// - Feedback latch: swallow 7..2, main 20..8, gain select 21, two ignored top bits.
// - Chip enable low powers down and floats pump; high powers up per power-down bit.
`timescale 1ns/1ps
`include "sdc_map.svh"

module sdc_core #(
	parameter int ERR_W = 8
) (
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	input  wire logic i_ser_clk,
	input  wire logic i_ser_data,
	input  wire logic i_load_strobe,
	input  wire logic i_chip_enable,
	input  wire logic i_ref_in,
	input  wire logic i_rf_in,
	output logic      o_pfd_up,
	output logic      o_pfd_down,
	output logic      o_cp_oe,
	output logic      o_cp_gain_sel,
	output logic      o_lock_detect,
	output logic      o_monitor_output
);

	// ----------------------------------------
	// Edge detection
	// ----------------------------------------
	logic ser_clk_q;
	logic load_q;
	logic ref_q;
	logic rf_q;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ser_clk_q <= 1'b0;
			load_q    <= 1'b0;
			ref_q     <= 1'b0;
			rf_q      <= 1'b0;
		end else begin
			ser_clk_q <= i_ser_clk;
			load_q    <= i_load_strobe;
			ref_q     <= i_ref_in;
			rf_q      <= i_rf_in;
		end
	end

	wire ser_rise  = i_ser_clk & ~ser_clk_q;
	wire load_rise = i_load_strobe & ~load_q;
	wire ref_rise  = i_ref_in & ~ref_q;
	wire rf_rise   = i_rf_in & ~rf_q;

	// ----------------------------------------
	// Serial shift register and latches
	// ----------------------------------------
	logic [`SDC_SHIFT_W-1:0] shreg;
	sdc_pkg::sdc_ref_cfg_t   ref_cfg;
	sdc_pkg::sdc_fb_cfg_t    fb_cfg;
	sdc_pkg::sdc_func_cfg_t  func_cfg;

	function automatic logic sdc_pick(input logic [1:0] sel, input logic [1:0] code);
		sdc_pick = (sel == code);
	endfunction

	wire [1:0] sel     = shreg[`SDC_SEL_MSB:`SDC_SEL_LSB];
	wire       ld_ref  = load_rise & sdc_pick(sel, `SDC_SEL_REF);
	wire       ld_fb   = load_rise & sdc_pick(sel, `SDC_SEL_FB);
	wire       ld_func = load_rise & sdc_pick(sel, `SDC_SEL_FUNC);
	wire       ld_init = load_rise & sdc_pick(sel, `SDC_SEL_INIT);

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			shreg <= '0;
		end else if (ser_rise) begin
			shreg <= {shreg[`SDC_SHIFT_W-2:0], i_ser_data};
		end
	end

	// The initialization latch shares the function layout, so it also reprograms the function settings.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ref_cfg  <= `SDC_REF_RST;
			fb_cfg   <= `SDC_FB_RST;
			func_cfg <= `SDC_FUNC_RST;
		end else begin
			if (ld_ref) begin
				ref_cfg <= shreg[`SDC_REF_MSB:`SDC_CFG_LSB];
			end
			if (ld_fb) begin
				fb_cfg <= shreg[`SDC_FB_MSB:`SDC_CFG_LSB];
			end
			if (ld_func | ld_init) begin
				func_cfg <= shreg[`SDC_FUNC_MSB:`SDC_CFG_LSB];
			end
		end
	end

	// ----------------------------------------
	// Power and counter hold
	// ----------------------------------------
	wire powered  = i_chip_enable & ~func_cfg.power_down_ctl_1;
	wire cnt_hold = ~powered | func_cfg.counter_reset | ld_init;

	// ----------------------------------------
	// Reference divider
	// ----------------------------------------
	logic [13:0] ref_cnt;
	wire  [13:0] ref_div   = (ref_cfg.ref_div == 14'h0000) ? 14'h0001 : ref_cfg.ref_div;
	wire         ref_tc    = ref_rise & (ref_cnt <= 14'h0001);
	wire         ref_pulse = ~cnt_hold & ref_tc;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ref_cnt <= 14'h0001;
		end else if (cnt_hold) begin
			ref_cnt <= ref_div;
		end else if (ref_rise) begin
			ref_cnt <= ref_tc ? ref_div : ref_cnt - 14'h0001;
		end
	end

	// ----------------------------------------
	// Prescaler with swallow and main counters
	// ----------------------------------------
	logic [6:0]  presc_cnt;
	logic [5:0]  swal_rem;
	logic [12:0] main_rem;

	wire [6:0] pmod        = `SDC_PRESC_BASE << func_cfg.prescaler;
	wire [6:0] plim        = (swal_rem != 6'h00) ? pmod : pmod - 7'h01;
	wire       presc_pulse = rf_rise & (presc_cnt >= plim);
	wire       fb_tc       = presc_pulse & (main_rem <= 13'h0001);
	wire       fb_pulse    = ~cnt_hold & fb_tc;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			presc_cnt <= 7'h00;
		end else if (cnt_hold | presc_pulse) begin
			presc_cnt <= 7'h00;
		end else if (rf_rise) begin
			presc_cnt <= presc_cnt + 7'h01;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			swal_rem <= 6'h00;
			main_rem <= 13'h0003;
		end else if (cnt_hold | fb_tc) begin
			swal_rem <= fb_cfg.swallow_count;
			main_rem <= fb_cfg.main_count;
		end else if (presc_pulse) begin
			main_rem <= main_rem - 13'h0001;
			if (swal_rem != 6'h00) begin
				swal_rem <= swal_rem - 6'h01;
			end
		end
	end

	// ----------------------------------------
	// Phase-frequency detector
	// ----------------------------------------
	sdc_pkg::sdc_pfd_state_t state;
	sdc_pkg::sdc_pfd_state_t next_state;
	logic [ERR_W-1:0]        err_cnt;
	logic [2:0]              abp_cnt;

	wire abp_done = (abp_cnt >= {1'b0, ref_cfg.backlash_width});

	always_comb begin
		next_state = state;
		case (state)
			sdc_pkg::SDC_PFD_IDLE: begin
				if (ref_pulse & fb_pulse) begin
					next_state = sdc_pkg::SDC_PFD_RST;
				end else if (ref_pulse) begin
					next_state = sdc_pkg::SDC_PFD_UP;
				end else if (fb_pulse) begin
					next_state = sdc_pkg::SDC_PFD_DN;
				end
			end
			sdc_pkg::SDC_PFD_UP: begin
				if (fb_pulse) begin
					next_state = sdc_pkg::SDC_PFD_RST;
				end
			end
			sdc_pkg::SDC_PFD_DN: begin
				if (ref_pulse) begin
					next_state = sdc_pkg::SDC_PFD_RST;
				end
			end
			sdc_pkg::SDC_PFD_RST: begin
				if (abp_done) begin
					next_state = sdc_pkg::SDC_PFD_IDLE;
				end
			end
			default: begin
				next_state = sdc_pkg::SDC_PFD_IDLE;
			end
		endcase
		if (!powered) begin
			next_state = sdc_pkg::SDC_PFD_IDLE;
		end
	end

	// Error is counted in whole clock periods, so detector resolution is one period.
	wire cyc_done = powered & (next_state == sdc_pkg::SDC_PFD_RST) & (state != sdc_pkg::SDC_PFD_RST);
	wire [ERR_W-1:0] meas = (state == sdc_pkg::SDC_PFD_IDLE) ? '0 : err_cnt;
	wire err_small = (meas < ERR_W'(`SDC_LOCK_WIN_CYC));
	wire err_large = (meas >= ERR_W'(`SDC_UNLOCK_CYC));

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state   <= sdc_pkg::SDC_PFD_IDLE;
			err_cnt <= '0;
			abp_cnt <= 3'h0;
		end else begin
			state   <= next_state;
			err_cnt <= (next_state == sdc_pkg::SDC_PFD_UP || next_state == sdc_pkg::SDC_PFD_DN) ?
				(err_cnt + ((&err_cnt) ? ERR_W'(0) : ERR_W'(1))) : '0;
			abp_cnt <= (next_state == sdc_pkg::SDC_PFD_RST && state == sdc_pkg::SDC_PFD_RST) ?
				abp_cnt + 3'h1 : 3'h0;
		end
	end

	// ----------------------------------------
	// Digital lock detect
	// ----------------------------------------
	logic [2:0] streak;
	logic       lock;
	wire  [2:0] need = ref_cfg.lock_precision_sel ? `SDC_STREAK_FINE : `SDC_STREAK_COARSE;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			streak <= 3'h0;
			lock   <= 1'b0;
		end else if (!powered) begin
			streak <= 3'h0;
			lock   <= 1'b0;
		end else if (cyc_done) begin
			if (lock) begin
				if (err_large) begin
					lock   <= 1'b0;
					streak <= 3'h0;
				end
			end else if (err_small) begin
				streak <= streak + 3'h1;
				lock   <= (streak + 3'h1 >= need);
			end else begin
				streak <= 3'h0;
			end
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	sdc_pkg::sdc_pump_t pump;
	wire sdc_pkg::sdc_mon_sel_t msel = sdc_pkg::sdc_mon_sel_t'(func_cfg.monitor_sel);
	logic mon_src;

	always_comb begin
		case (msel)
			sdc_pkg::SDC_MON_LOCK:   mon_src = lock;
			sdc_pkg::SDC_MON_FBDIV:  mon_src = fb_pulse;
			sdc_pkg::SDC_MON_HIGH:   mon_src = 1'b1;
			sdc_pkg::SDC_MON_REFDIV: mon_src = ref_pulse;
			sdc_pkg::SDC_MON_ALOCK:  mon_src = ~(state[0] ^ state[1]);
			sdc_pkg::SDC_MON_SDATA:  mon_src = shreg[`SDC_SHIFT_W-1];
			default:                 mon_src = 1'b0;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pump             <= '0;
			o_monitor_output <= 1'b0;
			o_lock_detect    <= 1'b0;
			o_cp_gain_sel    <= 1'b0;
		end else begin
			pump.up          <= next_state[0];
			pump.down        <= next_state[1];
			pump.cp_oe       <= powered & ~func_cfg.cp_three_state;
			o_monitor_output <= mon_src;
			o_lock_detect    <= lock;
			o_cp_gain_sel    <= fb_cfg.gain_select;
		end
	end

	assign o_pfd_up   = pump.up;
	assign o_pfd_down = pump.down;
	assign o_cp_oe    = pump.cp_oe;

endmodule

//--- include/sdc_map.svh
// Field positions, reset values and timing counts of the synthesizer divider core.
`ifndef SDC_MAP_SVH
`define SDC_MAP_SVH

// ----------------------------------------
// Shift word layout
// ----------------------------------------
`define SDC_SHIFT_W        24
`define SDC_SEL_MSB        1
`define SDC_SEL_LSB        0
`define SDC_CFG_LSB        2
`define SDC_REF_MSB        22
`define SDC_FB_MSB         21
`define SDC_FUNC_MSB       23

// ----------------------------------------
// Latch select codes
// ----------------------------------------
`define SDC_SEL_REF        2'h0
`define SDC_SEL_FB         2'h1
`define SDC_SEL_FUNC       2'h2
`define SDC_SEL_INIT       2'h3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SDC_REF_RST        21'h000001
`define SDC_FB_RST         20'h00300
`define SDC_FUNC_RST       22'h000000

// ----------------------------------------
// Timing
// ----------------------------------------
`define SDC_CLK_PERIOD_NS  100
`define SDC_LOCK_ERR_NS    15
`define SDC_UNLOCK_ERR_NS  25
`define SDC_MIN1(x)        (((x) < 1) ? 1 : (x))
`define SDC_LOCK_WIN_CYC   `SDC_MIN1((`SDC_LOCK_ERR_NS + `SDC_CLK_PERIOD_NS - 1) / `SDC_CLK_PERIOD_NS)
`define SDC_UNLOCK_CYC     `SDC_MIN1(`SDC_UNLOCK_ERR_NS / `SDC_CLK_PERIOD_NS)
`define SDC_STREAK_COARSE  3'h3
`define SDC_STREAK_FINE    3'h5
`define SDC_PRESC_BASE     7'h08

`endif

//--- include/sdc_pkg.sv
// Types shared by the synthesizer divider core.
package sdc_pkg;

	// ----------------------------------------
	// Configuration latches
	// ----------------------------------------
	typedef struct packed {
		logic        delay_option;
		logic        sync_option;
		logic        lock_precision_sel;
		logic        test_bit_hi;
		logic        test_bit_lo;
		logic [1:0]  backlash_width;
		logic [13:0] ref_div;
	} sdc_ref_cfg_t;

	typedef struct packed {
		logic        gain_select;
		logic [12:0] main_count;
		logic [5:0]  swallow_count;
	} sdc_fb_cfg_t;

	typedef struct packed {
		logic [1:0]  prescaler;
		logic        power_down_ctl_2;
		logic [2:0]  cp_current_2;
		logic [2:0]  cp_current_1;
		logic [3:0]  timer_ctl;
		logic        fastlock_mode;
		logic        fastlock_en;
		logic        cp_three_state;
		logic        power_down_mode_bit;
		logic [2:0]  monitor_sel;
		logic        power_down_ctl_1;
		logic        counter_reset;
	} sdc_func_cfg_t;

	// ----------------------------------------
	// Enumerations
	// ----------------------------------------
	typedef enum logic [1:0] {
		SDC_PFD_IDLE = 2'b00,
		SDC_PFD_UP   = 2'b01,
		SDC_PFD_DN   = 2'b10,
		SDC_PFD_RST  = 2'b11
	} sdc_pfd_state_t;

	typedef enum logic [2:0] {
		SDC_MON_LOW    = 3'b000,
		SDC_MON_LOCK   = 3'b001,
		SDC_MON_FBDIV  = 3'b010,
		SDC_MON_HIGH   = 3'b011,
		SDC_MON_REFDIV = 3'b100,
		SDC_MON_ALOCK  = 3'b101,
		SDC_MON_SDATA  = 3'b110,
		SDC_MON_GND    = 3'b111
	} sdc_mon_sel_t;

	typedef struct packed {
		logic up;
		logic down;
		logic cp_oe;
	} sdc_pump_t;

endpackage

//--- tb/sdc_core_sva.sv
// Port-level assertions for the synthesizer divider core.
`timescale 1ns/1ps
module sdc_core_sva (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_load_strobe,
	input wire logic i_chip_enable,
	input wire logic o_pfd_up,
	input wire logic o_pfd_down,
	input wire logic o_cp_oe,
	input wire logic o_cp_gain_sel,
	input wire logic o_lock_detect
);
	// ----
	// Helper state
	// ----
	logic       both;
	logic       both_q;
	logic       bad;
	logic [2:0] good;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	assign both = o_pfd_up && o_pfd_down;
	// Bad stays sticky only while locked, so a clear always has a visible cause.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			both_q <= 1'b0;
			bad    <= 1'b1;
			good   <= 3'h0;
		end else begin
			both_q <= both;
			bad    <= (bad && o_lock_detect) || (o_pfd_up ^ o_pfd_down) || !o_cp_oe;
			if ((o_pfd_up ^ o_pfd_down) || !i_chip_enable)
				good <= 3'h0;
			else if (both && !both_q && good != 3'h7)
				good <= good + 3'h1;
		end
	end
	// ----
	// Properties
	// ----
	sequence s_held_off; !i_chip_enable ##1 !i_chip_enable; endsequence
	sequence s_coincident; $rose(both); endsequence
	property p_pump_float; !i_chip_enable |=> !o_cp_oe; endproperty
	property p_off_quiet; s_held_off |-> (!o_pfd_up && !o_pfd_down) ##1 !o_lock_detect; endproperty
	property p_lock_coinc; $rose(o_lock_detect) |-> $past(both); endproperty
	property p_lock_streak; $rose(o_lock_detect) |-> good >= 3'h3; endproperty
	property p_backlash; s_coincident |-> ##[1:4] !both; endproperty
	property p_unlock_cause; $fell(o_lock_detect) |-> bad || !o_cp_oe; endproperty
	property p_gain_on_load; $changed(o_cp_gain_sel) |-> $past(i_load_strobe) || $past(i_load_strobe, 2); endproperty
	property p_lock_enabled; $rose(o_lock_detect) |-> $past(i_chip_enable); endproperty
	a_pump_float: assert property (p_pump_float) else $error("pump drives while off");
	a_off_quiet: assert property (p_off_quiet) else $error("outputs active while off");
	a_lock_coinc: assert property (p_lock_coinc) else $error("lock without coincidence");
	a_lock_streak: assert property (p_lock_streak) else $error("lock after short streak");
	a_backlash: assert property (p_backlash) else $error("reset pulse too long");
	a_unlock_cause: assert property (p_unlock_cause) else $error("lock cleared without error");
	a_gain_on_load: assert property (p_gain_on_load) else $error("gain changed without load");
	a_lock_enabled: assert property (p_lock_enabled) else $error("lock while off");
endmodule

bind sdc_core sdc_core_sva sdc_core_sva_i (.i_clk, .i_rst_n, .i_load_strobe, .i_chip_enable,
	.o_pfd_up, .o_pfd_down, .o_cp_oe, .o_cp_gain_sel, .o_lock_detect);

//--- tb/sdc_host.sv
// Serial host model that programs the core over its three-wire link.
`timescale 1ns/1ps
module sdc_host (
	input  wire logic i_clk,
	output logic      o_ser_clk,
	output logic      o_ser_data,
	output logic      o_load_strobe
);
	initial begin
		o_ser_clk = 1'b0;
		o_ser_data = 1'b0;
		o_load_strobe = 1'b0;
	end
	// Idle data shows the inverse of the last bit, so a late sample cannot match by luck.
	task automatic send(input logic [23:0] w, input logic strobe);
		for (int i = 23; i >= 0; i--) begin
			@(negedge i_clk);
			o_ser_data = w[i];
			o_ser_clk = 1'b0;
			@(negedge i_clk);
			o_ser_clk = 1'b1;
		end
		@(negedge i_clk);
		o_ser_clk = 1'b0;
		o_ser_data = ~w[0];
		@(negedge i_clk);
		o_load_strobe = strobe;
		@(negedge i_clk);
		o_load_strobe = 1'b0;
	endtask
endmodule

//--- tb/sdc_core_tb.sv
// Self-checking testbench of the synthesizer divider core.
`timescale 1ns/1ps
module sdc_core_tb;
	logic i_clk;
	logic i_rst_n;
	logic ser_clk;
	logic ser_data;
	logic strobe;
	logic chip_en;
	logic div_sig = 1'b0;
	logic up;
	logic down;
	logic cp_oe;
	logic gain;
	logic lock;
	logic mon;
	int   miscompares = 0;
	int   samples_checked = 0;
	int   t;
	sdc_host sdc_host_i (.i_clk(i_clk), .o_ser_clk(ser_clk), .o_ser_data(ser_data), .o_load_strobe(strobe));
	sdc_core sdc_core_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ser_clk(ser_clk), .i_ser_data(ser_data),
		.i_load_strobe(strobe), .i_chip_enable(chip_en), .i_ref_in(div_sig), .i_rf_in(div_sig),
		.o_pfd_up(up), .o_pfd_down(down), .o_cp_oe(cp_oe), .o_cp_gain_sel(gain),
		.o_lock_detect(lock), .o_monitor_output(mon));
	initial begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end
	// One shared input edge drives both dividers so their pulses can coincide.
	always @(negedge i_clk) div_sig <= ~div_sig;
	task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Words built by fw keep the prescaler at 8/9; the slowed input keeps the counters well within speed.
	function automatic logic [23:0] fw(input logic [2:0] m, input logic [1:0] sel);
		return {17'h0, m, 2'h0, sel};
	endfunction
	task automatic ld(input logic [23:0] w);
		sdc_host_i.send(w, 1'b1);
		repeat (3) @(negedge i_clk);
	endtask
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic t_shift;
		ld(fw(3'h6, 2'h2) | 24'h800000);
		chk("mon top bit", 24'h1, mon);
		sdc_host_i.send(24'h7fffff, 1'b0);
		repeat (3) @(negedge i_clk);
		chk("mon top bit", 24'h0, mon);
		$display("test shift done");
	endtask
	task automatic t_latch;
		ld(fw(3'h3, 2'h2));
		chk("mon high", 24'h1, mon);
		ld(24'hfffff0);
		chk("mon after ref", 24'h1, mon);
		ld(24'he00301);
		chk("gain", 24'h1, gain);
		chk("mon after fb", 24'h1, mon);
		ld(fw(3'h0, 2'h3));
		chk("mon init", 24'h0, mon);
		ld(fw(3'h3, 2'h2));
		ld(fw(3'h7, 2'h2));
		chk("mon gnd", 24'h0, mon);
		$display("test latch done");
	endtask
	task automatic t_lock(input logic prec, input int n);
		ld({3'h0, prec, 4'h0, 14'd26, 2'h0});
		ld({3'h0, 13'd3, 6'd2, 2'h1});
		chk("gain", 24'h0, gain);
		ld(fw(3'h1, 2'h2));
		chip_en = 1'b0;
		repeat (4) @(negedge i_clk);
		chk("oe off", 24'h0, cp_oe);
		chk("lock off", 24'h0, lock);
		chip_en = 1'b1;
		t = 0;
		while (!lock && t < 600) begin
			@(negedge i_clk);
			t++;
		end
		// One detector cycle is 26 input rises of 2 clocks each.
		chk("lock early", 24'h1, {23'h0, t > n * 52 - 12});
		chk("lock late", 24'h1, {23'h0, lock === 1'b1 && t <= n * 52 + 12});
		chk("mon lock", 24'h1, mon);
		chk("oe on", 24'h1, cp_oe);
		$display("test lock done");
	endtask
	task automatic t_unlock;
		repeat (300) @(negedge i_clk);
		chk("lock held", 24'h1, lock);
		ld({8'h0, 14'd27, 2'h0});
		t = 0;
		while (lock && t < 400) begin
			@(negedge i_clk);
			t++;
		end
		chk("lock cleared", 24'h0, lock);
		$display("test unlock done");
	endtask
	task automatic count_high(input int span, input int which, output int hits);
		hits = 0;
		repeat (span) begin
			@(negedge i_clk);
			if ((which == 0 && mon === 1'b1) || (which == 1 && up === 1'b1) || (which == 2 && down === 1'b1))
				hits++;
		end
	endtask
	// Locked with both dividers at 26, so a cycle is 52 clocks and a 520-clock span holds exactly ten.
	task automatic t_modes;
		int hits;
		ld(fw(3'h2, 2'h2));
		count_high(520, 0, hits);
		chk("fb pulses", 24'h00000a, 24'(hits));
		ld(fw(3'h4, 2'h2));
		count_high(520, 0, hits);
		chk("ref pulses", 24'h00000a, 24'(hits));
		count_high(520, 1, hits);
		chk("up narrow", 24'h00000a, 24'(hits));
		count_high(520, 2, hits);
		chk("down narrow", 24'h00000a, 24'(hits));
		ld({3'h0, 1'b1, 2'h0, 2'h3, 14'd26, 2'h0});
		count_high(520, 1, hits);
		chk("up wide", 24'h000028, 24'(hits));
		chk("lock kept", 24'h1, lock);
		ld(fw(3'h5, 2'h2));
		count_high(104, 0, hits);
		chk("alock high", 24'h000068, 24'(hits));
		ld(fw(3'h1, 2'h2) | 24'h000100);
		chk("oe three-state", 24'h0, cp_oe);
		chk("lock three-state", 24'h1, lock);
		ld(fw(3'h1, 2'h2) | 24'h000008);
		chk("oe power bit", 24'h0, cp_oe);
		chk("lock power bit", 24'h0, lock);
		ld(fw(3'h2, 2'h2) | 24'h000004);
		count_high(104, 0, hits);
		chk("fb held", 24'h0, 24'(hits));
		$display("test modes done");
	endtask
	initial begin
		i_rst_n = 1'b0;
		chip_en = 1'b1;
		repeat (10) @(negedge i_clk);
		chk("lock in reset", 24'h0, lock);
		chk("oe in reset", 24'h0, cp_oe);
		i_rst_n = 1'b1;
		t_shift;
		t_latch;
		t_lock(1'b0, 3);
		t_unlock;
		t_lock(1'b1, 5);
		t_modes;
		wrap_up;
	end
	initial begin
		#(100 * 20000);
		miscompares++;
		wrap_up;
	end
endmodule
